// ---- design/mge_pkg.sv ----
package mge_pkg;
  // register indices; byte address is four times the index
  localparam logic [6:0] IDX_TAP_RESULT     = 7'h35;
  localparam logic [6:0] IDX_MOTION_STATUS  = 7'h37;
  localparam logic [6:0] IDX_GESTURE_STATUS = 7'h38;
  localparam logic [6:0] IDX_SLEEP_TIMEOUT  = 7'h43;
  localparam logic [6:0] IDX_ORIENTATION    = 7'h44;
  localparam logic [6:0] IDX_SLEEP_WAIT     = 7'h45;
  localparam logic [6:0] IDX_TAP_THRESHOLD  = 7'h46;
  localparam logic [6:0] IDX_TAP_TIMING     = 7'h47;
  localparam logic [6:0] IDX_X_THRESHOLD    = 7'h4A;
  localparam logic [6:0] IDX_ENGINE_INIT    = 7'h4B;
  localparam logic [6:0] IDX_Y_THRESHOLD    = 7'h4B;
  localparam logic [6:0] IDX_Z_THRESHOLD    = 7'h4C;
  localparam logic [6:0] IDX_LP_CLOCK       = 7'h4D;
  localparam logic [6:0] IDX_LINE1_GESTURE  = 7'h4D;
  localparam logic [6:0] IDX_POWER          = 7'h4E;
  localparam logic [6:0] IDX_LINE2_GESTURE  = 7'h4E;
  localparam logic [6:0] IDX_ACCEL_RATE     = 7'h50;
  localparam logic [6:0] IDX_FILTER_BW      = 7'h52;
  localparam logic [6:0] IDX_FILTER_ORDER   = 7'h53;
  localparam logic [6:0] IDX_FEATURE_ENABLE = 7'h56;
  localparam logic [6:0] IDX_MOTION_MODE    = 7'h57;
  localparam logic [6:0] IDX_LINE1_MOTION   = 7'h66;
  localparam logic [6:0] IDX_LINE2_MOTION   = 7'h69;
  localparam logic [6:0] IDX_BANK_SELECT    = 7'h76;
  localparam int         ADDR_INDEX_LSB     = 2;
  localparam int         ADDR_INDEX_MSB     = 8;

  localparam logic [2:0] BANK_0 = 3'h0;
  localparam logic [2:0] BANK_4 = 3'h4;

  // values after reset
  localparam logic [7:0] RST_ZERO          = 8'h00;
  localparam logic [7:0] RST_SLEEP_TIMEOUT = 8'h00;
  localparam logic [7:0] RST_ORIENTATION   = 8'h00;
  localparam logic [7:0] RST_SLEEP_WAIT    = 8'h00;
  localparam logic [7:0] RST_TAP_THRESHOLD = 8'h46;
  localparam logic [7:0] RST_TAP_TIMING    = 8'h4F;
  localparam logic [7:0] RST_MOTION_THR    = 8'h62;

  // field positions
  localparam int FEAT_RATE_LSB   = 0;
  localparam int FEAT_RAISE_BIT  = 3;
  localparam int FEAT_TAP_BIT    = 6;
  localparam int INIT_CLEAR_BIT  = 5;
  localparam int INIT_START_BIT  = 6;
  localparam int MODE_SIG_LSB    = 0;
  localparam int MODE_COMPARE    = 2;
  localparam int MODE_COMBINE    = 3;
  localparam int MODE_WINDOW     = 4;
  localparam int GEST_TAP        = 0;
  localparam int GEST_SLEEP      = 1;
  localparam int GEST_WAKE       = 2;
  localparam int MOT_SIG         = 3;
  localparam int GEST_FLAGS      = 3;
  localparam int MOT_FLAGS       = 4;

  // mode and rate codes
  localparam logic [1:0] ENGINE_RATE_25HZ = 2'h0;
  localparam logic [1:0] ENGINE_RATE_50HZ = 2'h2;
  localparam logic [3:0] ACCEL_RATE_50HZ  = 4'h9;
  localparam logic [3:0] ACCEL_RATE_25HZ  = 4'hA;
  localparam logic [3:0] ACCEL_RATE_500HZ = 4'hF;
  localparam logic [1:0] SIG_MODE_MOT     = 2'h1;
  localparam logic [1:0] SIG_MODE_SIG     = 2'h3;

  // significant motion windows
  localparam int CLK_HZ         = 100_000_000;
  localparam int WIN_SHORT_S    = 2;
  localparam int WIN_LONG_S     = 4;
  localparam int WIN_SHORT_CYC  = WIN_SHORT_S * CLK_HZ;
  localparam int WIN_LONG_CYC   = WIN_LONG_S * CLK_HZ;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- design/mge_event_flags.sv ----
`timescale 1ns/10ps
module mge_event_flags #(
  parameter int W = 4
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] set_evt,
  input  wire logic         clear_on_read,
  output logic      [W-1:0] flags
);
  typedef struct packed {
    logic [W-1:0] flags;
  } mge_flag_state_t;

  mge_flag_state_t s;
  mge_flag_state_t next_s;

  always_comb begin
    next_s = s;
    if (clear_on_read) begin
      next_s.flags = '0;
    end
    // an event in the clearing cycle survives the read
    next_s.flags = next_s.flags | set_evt; // see R24
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign flags = s.flags;
endmodule // mge_event_flags

// ---- design/mge_top.sv ----
// Function
// R1: gesture route bits 2,1 send wake and sleep events to line one or two.
// R2: raise gesture detection runs only while its feature enable bit is one.
// R3: wake and sleep gestures each set a flag in gesture status.
// R4: sleep timeout, orientation and sleep wait registers hold defaults until written.
// R5: engine rate code 0 selects 25 Hz and code 2 selects 50 Hz.
// R6: software clears engine memory, waits 1 ms per write, then sets init.
// R7: software waits 50 ms between routing enable and feature enable.
// R8: gesture route bit 0 sends tap events to line one or two.
// R9: tap stores count, axis and polarity and sets the tap flag.
// R10: tap timing and threshold fields default to 2, 3, 3, 17 and 2.
// R11: software picks accel rate code 15 for tap detection.
// R12: software uses low power mode and filter order 2, bandwidth 4.
// R13: at 1 kHz software uses low noise mode, order 2, bandwidth 0.
// R14: per-axis motion thresholds sit at 0x4A to 0x4C, default 98.
// R15: motion route bits 2 to 0 send axis motion events to each line.
// R16: wake on motion runs with combine 0, compare 1, significant mode 1.
// R17: significant motion runs with combine 0, compare 1, significant mode 3.
// R18: threshold crossings flag separately per axis in motion status.
// R19: motion route bit 3 sends significant motion events to each line.
// R20: significant motion sets its flag in motion status.
// R21: accel rate code 9 means 50 Hz and code 10 means 25 Hz.
// R22: gesture features stay off while the accel rate is under 25 Hz.
// R23: significant motion needs two motion events within a 2 s or 4 s window.
// R24: flags hold until their status register is read; lines follow routed flags.
`timescale 1ns/10ps
module mge_top #(
  parameter int          ADDR_W        = 12,
  parameter int unsigned WIN_SHORT_CYC = mge_pkg::WIN_SHORT_CYC,
  parameter int unsigned WIN_LONG_CYC  = mge_pkg::WIN_LONG_CYC
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              wake_gesture_evt,
  input  wire logic              sleep_gesture_evt,
  input  wire logic              tap_evt,
  input  wire logic [1:0]        tap_count,
  input  wire logic [1:0]        tap_axis,
  input  wire logic              tap_dir,
  input  wire logic              motion_sample_valid,
  input  wire logic [7:0]        x_motion_delta,
  input  wire logic [7:0]        y_motion_delta,
  input  wire logic [7:0]        z_motion_delta,
  output logic                   interrupt_line_one,
  output logic                   interrupt_line_two,
  output logic                   raise_detect_run,
  output logic                   tap_detect_run,
  output logic                   wake_on_motion_run,
  output logic                   significant_motion_run,
  output logic                   engine_rate_50hz,
  output logic [7:0]             orientation_matrix,
  output logic [7:0]             gesture_sleep_timeout,
  output logic [7:0]             gesture_sleep_wait,
  output logic [7:0]             tap_timing,
  output logic [7:0]             tap_threshold
);
  typedef enum logic [4:0] {
    SEL_NONE      = 5'b00000,
    SEL_TAP_RES   = 5'b00001,
    SEL_MOT_STAT  = 5'b00010,
    SEL_GEST_STAT = 5'b00011,
    SEL_SLEEP_TO  = 5'b00100,
    SEL_ORIENT    = 5'b00101,
    SEL_SLEEP_WT  = 5'b00110,
    SEL_TAP_THR   = 5'b00111,
    SEL_TAP_TIM   = 5'b01000,
    SEL_X_THR     = 5'b01001,
    SEL_INIT      = 5'b01010,
    SEL_Y_THR     = 5'b01011,
    SEL_Z_THR     = 5'b01100,
    SEL_LP_CLK    = 5'b01101,
    SEL_L1_GEST   = 5'b01110,
    SEL_POWER     = 5'b01111,
    SEL_L2_GEST   = 5'b10000,
    SEL_RATE      = 5'b10001,
    SEL_FILT_BW   = 5'b10010,
    SEL_FILT_ORD  = 5'b10011,
    SEL_FEAT      = 5'b10100,
    SEL_MODE      = 5'b10101,
    SEL_L1_MOT    = 5'b10110,
    SEL_L2_MOT    = 5'b10111,
    SEL_BANK      = 5'b11000
  } mge_sel_t;

  typedef struct packed {
    logic [2:0]  bank;
    logic [7:0]  sleep_timeout;
    logic [7:0]  orient;
    logic [7:0]  sleep_wait;
    logic [7:0]  tap_thr;
    logic [7:0]  tap_tim;
    logic [7:0]  x_thr;
    logic [7:0]  y_thr;
    logic [7:0]  z_thr;
    logic [7:0]  init_ctl;
    logic [7:0]  lp_clk;
    logic [7:0]  line1_gest;
    logic [7:0]  power;
    logic [7:0]  line2_gest;
    logic [7:0]  rate;
    logic [7:0]  filt_bw;
    logic [7:0]  filt_ord;
    logic [7:0]  feat;
    logic [7:0]  mode;
    logic [7:0]  line1_mot;
    logic [7:0]  line2_mot;
    logic [7:0]  tap_res;
    logic        engine_ready;
    logic [31:0] sig_count;
    logic        aw_held;
    logic [6:0]  aw_idx;
    logic        aw_bad;
    logic        w_held;
    logic [7:0]  wdata;
    logic        wstrb0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [7:0]  rdata;
    logic        irq1;
    logic        irq2;
    logic        raise_run;
    logic        tap_run;
    logic        mot_run;
    logic        sig_run;
  } mge_state_t;

  mge_state_t s;
  mge_state_t next_s;

  logic [mge_pkg::GEST_FLAGS-1:0] gest_set;
  logic [mge_pkg::GEST_FLAGS-1:0] gest_flags;
  logic [mge_pkg::MOT_FLAGS-1:0]  mot_set;
  logic [mge_pkg::MOT_FLAGS-1:0]  mot_flags;
  logic                           gest_clear;
  logic                           mot_clear;

  function automatic mge_sel_t decode(input logic [6:0] idx, input logic [2:0] bank);
    mge_sel_t sel;
    sel = SEL_NONE;
    if (idx == mge_pkg::IDX_BANK_SELECT) begin
      sel = SEL_BANK;
    end else if (bank == mge_pkg::BANK_4) begin
      if (idx == mge_pkg::IDX_SLEEP_TIMEOUT) sel = SEL_SLEEP_TO;
      else if (idx == mge_pkg::IDX_ORIENTATION) sel = SEL_ORIENT;
      else if (idx == mge_pkg::IDX_SLEEP_WAIT) sel = SEL_SLEEP_WT;
      else if (idx == mge_pkg::IDX_TAP_THRESHOLD) sel = SEL_TAP_THR;
      else if (idx == mge_pkg::IDX_TAP_TIMING) sel = SEL_TAP_TIM;
      else if (idx == mge_pkg::IDX_X_THRESHOLD) sel = SEL_X_THR;
      else if (idx == mge_pkg::IDX_Y_THRESHOLD) sel = SEL_Y_THR;
      else if (idx == mge_pkg::IDX_Z_THRESHOLD) sel = SEL_Z_THR;
      else if (idx == mge_pkg::IDX_LINE1_GESTURE) sel = SEL_L1_GEST;
      else if (idx == mge_pkg::IDX_LINE2_GESTURE) sel = SEL_L2_GEST;
    end else if (bank == mge_pkg::BANK_0) begin
      if (idx == mge_pkg::IDX_TAP_RESULT) sel = SEL_TAP_RES;
      else if (idx == mge_pkg::IDX_MOTION_STATUS) sel = SEL_MOT_STAT;
      else if (idx == mge_pkg::IDX_GESTURE_STATUS) sel = SEL_GEST_STAT;
      else if (idx == mge_pkg::IDX_ENGINE_INIT) sel = SEL_INIT;
      else if (idx == mge_pkg::IDX_LP_CLOCK) sel = SEL_LP_CLK;
      else if (idx == mge_pkg::IDX_POWER) sel = SEL_POWER;
      else if (idx == mge_pkg::IDX_ACCEL_RATE) sel = SEL_RATE;
      else if (idx == mge_pkg::IDX_FILTER_BW) sel = SEL_FILT_BW;
      else if (idx == mge_pkg::IDX_FILTER_ORDER) sel = SEL_FILT_ORD;
      else if (idx == mge_pkg::IDX_FEATURE_ENABLE) sel = SEL_FEAT;
      else if (idx == mge_pkg::IDX_MOTION_MODE) sel = SEL_MODE;
      else if (idx == mge_pkg::IDX_LINE1_MOTION) sel = SEL_L1_MOT;
      else if (idx == mge_pkg::IDX_LINE2_MOTION) sel = SEL_L2_MOT;
    end
    return sel;
  endfunction

  // accel rate codes 11 to 14 sit below 25 Hz; code 15 is the 500 Hz tap rate
  function automatic logic accel_rate_ok(input logic [3:0] code);
    return (code <= mge_pkg::ACCEL_RATE_25HZ) || (code == mge_pkg::ACCEL_RATE_500HZ);
  endfunction

  logic                  aw_hs;
  logic                  w_hs;
  logic                  ar_hs;
  logic                  aw_bad_in;
  logic                  ar_bad_in;
  mge_sel_t              wsel;
  mge_sel_t              rsel;
  logic [7:0]            rval;
  logic                  gest_ok;
  logic                  engine_rate_ok;
  logic                  mot_mode;
  logic                  sig_mode;
  logic [2:0]            axis_cross;
  logic                  sig_evt;
  logic [31:0]           sig_window;
  logic [1:0]            engine_code;

  assign s_axi_awready = !s.aw_held && !s.bvalid;
  assign s_axi_wready  = !s.w_held && !s.bvalid;
  assign s_axi_arready = !s.rvalid;
  assign aw_hs         = s_axi_awvalid && s_axi_awready;
  assign w_hs          = s_axi_wvalid && s_axi_wready;
  assign ar_hs         = s_axi_arvalid && s_axi_arready;
  assign aw_bad_in     = s_axi_awaddr[ADDR_W-1:mge_pkg::ADDR_INDEX_MSB+1] != '0;
  assign ar_bad_in     = s_axi_araddr[ADDR_W-1:mge_pkg::ADDR_INDEX_MSB+1] != '0;
  assign wsel          = s.aw_bad ? SEL_NONE : decode(s.aw_idx, s.bank);
  assign rsel          = ar_bad_in ? SEL_NONE :
                         decode(s_axi_araddr[mge_pkg::ADDR_INDEX_MSB:mge_pkg::ADDR_INDEX_LSB],
                                s.bank);

  // reading a status register clears it on the same edge that samples it
  assign gest_clear = ar_hs && (rsel == SEL_GEST_STAT); // see R24
  assign mot_clear  = ar_hs && (rsel == SEL_MOT_STAT); // see R24

  assign engine_code    = s.feat[mge_pkg::FEAT_RATE_LSB +: 2];
  assign engine_rate_ok = (engine_code == mge_pkg::ENGINE_RATE_25HZ) ||
                          (engine_code == mge_pkg::ENGINE_RATE_50HZ); // see R5
  assign gest_ok = s.engine_ready && engine_rate_ok && accel_rate_ok(s.rate[3:0]); // see R22 R21

  assign mot_mode = !s.mode[mge_pkg::MODE_COMBINE] && s.mode[mge_pkg::MODE_COMPARE] &&
                    ((s.mode[mge_pkg::MODE_SIG_LSB +: 2] == mge_pkg::SIG_MODE_MOT) ||
                     (s.mode[mge_pkg::MODE_SIG_LSB +: 2] == mge_pkg::SIG_MODE_SIG)); // see R16
  assign sig_mode = !s.mode[mge_pkg::MODE_COMBINE] && s.mode[mge_pkg::MODE_COMPARE] &&
                    (s.mode[mge_pkg::MODE_SIG_LSB +: 2] == mge_pkg::SIG_MODE_SIG); // see R17

  // each axis compares on its own threshold
  assign axis_cross[0] = s.mot_run && motion_sample_valid && (x_motion_delta > s.x_thr); // see R18
  assign axis_cross[1] = s.mot_run && motion_sample_valid && (y_motion_delta > s.y_thr); // see R18
  assign axis_cross[2] = s.mot_run && motion_sample_valid && (z_motion_delta > s.z_thr); // see R18
  assign sig_window    = s.mode[mge_pkg::MODE_WINDOW] ? 32'(WIN_LONG_CYC) : 32'(WIN_SHORT_CYC);
  // a second crossing inside an open window declares significant motion
  assign sig_evt       = s.sig_run && (|axis_cross) && (s.sig_count != 32'h0); // see R23

  assign gest_set[mge_pkg::GEST_WAKE]  = s.raise_run && wake_gesture_evt; // see R3
  assign gest_set[mge_pkg::GEST_SLEEP] = s.raise_run && sleep_gesture_evt; // see R3
  assign gest_set[mge_pkg::GEST_TAP]   = s.tap_run && tap_evt; // see R9
  assign mot_set = {sig_evt, axis_cross}; // see R20

  always_comb begin
    rval = 8'h00;
    case (rsel)
      SEL_TAP_RES:   rval = s.tap_res;
      SEL_MOT_STAT:  rval = 8'(mot_flags);
      SEL_GEST_STAT: rval = 8'(gest_flags);
      SEL_SLEEP_TO:  rval = s.sleep_timeout;
      SEL_ORIENT:    rval = s.orient;
      SEL_SLEEP_WT:  rval = s.sleep_wait;
      SEL_TAP_THR:   rval = s.tap_thr;
      SEL_TAP_TIM:   rval = s.tap_tim;
      SEL_X_THR:     rval = s.x_thr;
      SEL_INIT:      rval = s.init_ctl;
      SEL_Y_THR:     rval = s.y_thr;
      SEL_Z_THR:     rval = s.z_thr;
      SEL_LP_CLK:    rval = s.lp_clk;
      SEL_L1_GEST:   rval = s.line1_gest;
      SEL_POWER:     rval = s.power;
      SEL_L2_GEST:   rval = s.line2_gest;
      SEL_RATE:      rval = s.rate;
      SEL_FILT_BW:   rval = s.filt_bw;
      SEL_FILT_ORD:  rval = s.filt_ord;
      SEL_FEAT:      rval = s.feat;
      SEL_MODE:      rval = s.mode;
      SEL_L1_MOT:    rval = s.line1_mot;
      SEL_L2_MOT:    rval = s.line2_mot;
      SEL_BANK:      rval = {5'h00, s.bank};
      default:       rval = 8'h00;
    endcase
  end

  always_comb begin
    next_s = s;
    if (aw_hs) begin
      next_s.aw_held = 1'b1;
      next_s.aw_idx  = s_axi_awaddr[mge_pkg::ADDR_INDEX_MSB:mge_pkg::ADDR_INDEX_LSB];
      next_s.aw_bad  = aw_bad_in;
    end
    if (w_hs) begin
      next_s.w_held = 1'b1;
      next_s.wdata  = s_axi_wdata[7:0];
      next_s.wstrb0 = s_axi_wstrb[0];
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.aw_held && s.w_held) begin
      next_s.aw_held = 1'b0;
      next_s.w_held  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = (wsel == SEL_NONE) ? mge_pkg::RESP_SLVERR : mge_pkg::RESP_OKAY;
      if (s.wstrb0) begin
        case (wsel)
          SEL_SLEEP_TO: next_s.sleep_timeout = s.wdata; // see R4
          SEL_ORIENT:   next_s.orient        = s.wdata; // see R4
          SEL_SLEEP_WT: next_s.sleep_wait    = s.wdata; // see R4
          SEL_TAP_THR:  next_s.tap_thr       = s.wdata; // see R10
          SEL_TAP_TIM:  next_s.tap_tim       = s.wdata; // see R10
          SEL_X_THR:    next_s.x_thr         = s.wdata; // see R14
          SEL_Y_THR:    next_s.y_thr         = s.wdata; // see R14
          SEL_Z_THR:    next_s.z_thr         = s.wdata; // see R14
          SEL_INIT: begin
            next_s.init_ctl = s.wdata;
            // clearing engine memory wins over a start in the same write
            if (s.wdata[mge_pkg::INIT_CLEAR_BIT]) begin
              next_s.engine_ready = 1'b0; // see R6
            end else if (s.wdata[mge_pkg::INIT_START_BIT]) begin
              next_s.engine_ready = 1'b1; // see R6
            end
          end
          SEL_LP_CLK:   next_s.lp_clk     = s.wdata;
          SEL_L1_GEST:  next_s.line1_gest = s.wdata;
          SEL_POWER:    next_s.power      = s.wdata;
          SEL_L2_GEST:  next_s.line2_gest = s.wdata;
          SEL_RATE:     next_s.rate       = s.wdata;
          SEL_FILT_BW:  next_s.filt_bw    = s.wdata;
          SEL_FILT_ORD: next_s.filt_ord   = s.wdata;
          SEL_FEAT:     next_s.feat       = s.wdata;
          SEL_MODE:     next_s.mode       = s.wdata;
          SEL_L1_MOT:   next_s.line1_mot  = s.wdata;
          SEL_L2_MOT:   next_s.line2_mot  = s.wdata;
          SEL_BANK:     next_s.bank       = s.wdata[2:0];
          default:      next_s.bank       = s.bank;
        endcase
      end
    end
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (ar_hs) begin
      next_s.rvalid = 1'b1;
      next_s.rdata  = rval;
      next_s.rresp  = (rsel == SEL_NONE) ? mge_pkg::RESP_SLVERR : mge_pkg::RESP_OKAY;
    end
    if (gest_set[mge_pkg::GEST_TAP]) begin
      next_s.tap_res = {3'h0, tap_count, tap_axis, tap_dir}; // see R9
    end
    // the window restarts on any crossing that did not close it
    if (!s.sig_run || sig_evt) begin
      next_s.sig_count = 32'h0; // see R23
    end else if (|axis_cross) begin
      next_s.sig_count = sig_window; // see R23
    end else if (s.sig_count != 32'h0) begin
      next_s.sig_count = s.sig_count - 32'h1;
    end
    next_s.raise_run = gest_ok && s.feat[mge_pkg::FEAT_RAISE_BIT]; // see R2 R22
    next_s.tap_run   = gest_ok && s.feat[mge_pkg::FEAT_TAP_BIT]; // see R22
    next_s.mot_run   = mot_mode; // see R16
    next_s.sig_run   = sig_mode; // see R17
    next_s.irq1 = (|(gest_flags & s.line1_gest[2:0])) || // see R1 R8 R24
                  (|(mot_flags & s.line1_mot[3:0])); // see R15 R19
    next_s.irq2 = (|(gest_flags & s.line2_gest[2:0])) || // see R1 R8 R24
                  (|(mot_flags & s.line2_mot[3:0])); // see R15 R19
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s               <= '0;
      s.sleep_timeout <= mge_pkg::RST_SLEEP_TIMEOUT; // see R4
      s.orient        <= mge_pkg::RST_ORIENTATION; // see R4
      s.sleep_wait    <= mge_pkg::RST_SLEEP_WAIT; // see R4
      s.tap_thr       <= mge_pkg::RST_TAP_THRESHOLD; // see R10
      s.tap_tim       <= mge_pkg::RST_TAP_TIMING; // see R10
      s.x_thr         <= mge_pkg::RST_MOTION_THR; // see R14
      s.y_thr         <= mge_pkg::RST_MOTION_THR; // see R14
      s.z_thr         <= mge_pkg::RST_MOTION_THR; // see R14
      s.bank          <= mge_pkg::BANK_0;
    end else begin
      s <= next_s;
    end
  end

  mge_event_flags #(
    .W(mge_pkg::GEST_FLAGS)
  ) u_gest_flags (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .set_evt       (gest_set),
    .clear_on_read (gest_clear),
    .flags         (gest_flags)
  );

  mge_event_flags #(
    .W(mge_pkg::MOT_FLAGS)
  ) u_mot_flags (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .set_evt       (mot_set),
    .clear_on_read (mot_clear),
    .flags         (mot_flags)
  );

  assign s_axi_bvalid           = s.bvalid;
  assign s_axi_bresp            = s.bresp;
  assign s_axi_rvalid           = s.rvalid;
  assign s_axi_rresp            = s.rresp;
  assign s_axi_rdata            = {24'h000000, s.rdata};
  assign interrupt_line_one     = s.irq1;
  assign interrupt_line_two     = s.irq2;
  assign raise_detect_run       = s.raise_run;
  assign tap_detect_run         = s.tap_run;
  assign wake_on_motion_run     = s.mot_run;
  assign significant_motion_run = s.sig_run;
  assign engine_rate_50hz       = engine_code == mge_pkg::ENGINE_RATE_50HZ; // see R5
  assign orientation_matrix     = s.orient;
  assign gesture_sleep_timeout  = s.sleep_timeout;
  assign gesture_sleep_wait     = s.sleep_wait;
  assign tap_timing             = s.tap_tim;
  assign tap_threshold          = s.tap_thr;
endmodule // mge_top

// ---- testbench/mge_checker.sv ----
`timescale 1ns/10ps
module mge_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        interrupt_line_one,
  input wire logic        interrupt_line_two
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("b lost");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("r lost");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar open");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("aw open");
  r_cause_a: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid) && $past(s_axi_arready))
    else $error("r uncaused");
  b_wait_a: assert property ($rose(s_axi_bvalid) |-> !$past(s_axi_awready)) else $error("b early");
  r_width_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("r high");
  rst_quiet_a: assert property ($rose(aresetn) |-> !interrupt_line_one && !interrupt_line_two)
    else $error("int after reset");
endmodule // mge_checker
bind mge_top mge_checker mge_checker_inst (.*);

// ---- testbench/testbench.sv ----
`timescale 1ns/10ps
module testbench;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, tap_evt = 0, tap_dir = 0, motion_sample_valid = 0;
  logic wake_gesture_evt = 0, sleep_gesture_evt = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, interrupt_line_one, interrupt_line_two, raise_detect_run;
  logic tap_detect_run, wake_on_motion_run, significant_motion_run, engine_rate_50hz;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp, tap_count = 0, tap_axis = 0;
  logic [7:0]  x_motion_delta = 0, y_motion_delta = 0, z_motion_delta = 0, orientation_matrix;
  logic [7:0]  gesture_sleep_timeout, gesture_sleep_wait, tap_timing, tap_threshold;
  int          n_mismatch = 0, tests_run = 0;
  mge_top #(.WIN_SHORT_CYC(20), .WIN_LONG_CYC(40)) mge_top_inst (.*);
  initial forever #5 aclk = ~aclk;
  task cmp(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input logic [6:0] i, input logic [7:0] d);
    s_axi_awaddr <= {3'h0, i, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) break;
    end
    cmp({30'h0, s_axi_bresp}, 32'h00000000);
  endtask
  task rd(input logic [6:0] i, input logic [7:0] d, input logic [1:0] e);
    s_axi_araddr <= {3'h0, i, 2'h0};
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) break;
    end
    cmp(s_axi_rdata, {24'h0, d});
    cmp({30'h0, s_axi_rresp}, {30'h0, e});
  endtask
  task t_defaults;
    wr(mge_pkg::IDX_BANK_SELECT, 8'h04);
    rd(mge_pkg::IDX_SLEEP_TIMEOUT, 8'h00, 2'h0);
    rd(mge_pkg::IDX_TAP_THRESHOLD, 8'h46, 2'h0);
    rd(mge_pkg::IDX_TAP_TIMING, 8'h4F, 2'h0);
    rd(mge_pkg::IDX_X_THRESHOLD, 8'h62, 2'h0);
    cmp({gesture_sleep_timeout, gesture_sleep_wait, tap_timing, tap_threshold}, 32'h00004F46);
    wr(mge_pkg::IDX_ORIENTATION, 8'h5A);
    cmp({24'h000000, orientation_matrix}, 32'h0000005A);
    rd(7'h7F, 8'h00, 2'h2);
  endtask
  task t_tap;
    wr(mge_pkg::IDX_LINE1_GESTURE, 8'h01);
    wr(mge_pkg::IDX_LINE2_GESTURE, 8'h06);
    wr(mge_pkg::IDX_BANK_SELECT, 8'h00);
    wr(mge_pkg::IDX_ENGINE_INIT, 8'h20);
    wr(mge_pkg::IDX_ENGINE_INIT, 8'h40);
    wr(mge_pkg::IDX_ACCEL_RATE, 8'h0F);
    wr(mge_pkg::IDX_POWER, 8'h02);
    wr(mge_pkg::IDX_FILTER_ORDER, 8'h02);
    wr(mge_pkg::IDX_FILTER_BW, 8'h04);
    wr(mge_pkg::IDX_FEATURE_ENABLE, 8'h4A);
    repeat (2) @(posedge aclk);
    cmp(engine_rate_50hz, 1);
    cmp({30'h0, raise_detect_run, tap_detect_run}, 32'h00000003);
    tap_count <= 2'h2;
    tap_axis <= 2'h1;
    tap_dir <= 1;
    tap_evt <= 1;
    wake_gesture_evt <= 1;
    @(posedge aclk);
    tap_evt <= 0;
    wake_gesture_evt <= 0;
    repeat (2) @(posedge aclk);
    cmp({interrupt_line_one, interrupt_line_two}, 2'h3);
    rd(mge_pkg::IDX_TAP_RESULT, 8'h13, 2'h0);
    rd(mge_pkg::IDX_GESTURE_STATUS, 8'h05, 2'h0);
    repeat (2) @(posedge aclk);
    cmp(interrupt_line_one, 0);
    rd(mge_pkg::IDX_GESTURE_STATUS, 8'h00, 2'h0);
    wr(mge_pkg::IDX_ACCEL_RATE, 8'h0B);
    repeat (2) @(posedge aclk);
    cmp({30'h0, raise_detect_run, tap_detect_run}, 32'h00000000);
    wr(mge_pkg::IDX_POWER, 8'h01);
    rd(mge_pkg::IDX_POWER, 8'h01, 2'h0);
  endtask
  task t_motion;
    wr(mge_pkg::IDX_MOTION_MODE, 8'h07);
    wr(mge_pkg::IDX_LINE1_MOTION, 8'h0F);
    repeat (2) @(posedge aclk);
    cmp({wake_on_motion_run, significant_motion_run}, 2'h3);
    x_motion_delta <= 8'd98;
    z_motion_delta <= 8'd99;
    motion_sample_valid <= 1;
    @(posedge aclk);
    z_motion_delta <= 8'd0;
    y_motion_delta <= 8'd99;
    @(posedge aclk);
    motion_sample_valid <= 0;
    repeat (2) @(posedge aclk);
    cmp(interrupt_line_one, 1);
    rd(mge_pkg::IDX_MOTION_STATUS, 8'h0E, 2'h0);
  endtask
  task complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    t_defaults;
    t_tap;
    t_motion;
    complete_run;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    complete_run;
  end
endmodule // testbench
